// ===== src/tper_pkg.sv
//==============================================================
// Summary of operation
// - touch status shows every pressed pad at once, not one pad
// - sensor interrupt pin rises on any touch event in non-buffered mode, on a logged entry while armed, or on a fault
// - the first read of the FIFO register drops the sensor interrupt pin
// - after that read, buffered data re-raises the pin only once FIFO emptied
// - touch buffer type logs an entry on every pad press
// - release buffer type logs an entry on every pad release
// - combined buffer type logs both press and release
package tper_pkg;

  // ==============================================================
  // sizes
  localparam int PADS = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int ENTRY_W = 4;
  localparam int ADDR_W = 8;

  // ==============================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TOUCH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FIFO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LEVEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_ISTAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h14;

  // ==============================================================
  // field positions
  localparam int FIFO_EMPTY_BIT = 8;
  localparam int ENTRY_KIND_BIT = 3;
  localparam int ISTAT_W = 3;
  localparam int IS_TOUCH = 0;
  localparam int IS_FAULT = 1;
  localparam int IS_DATA = 2;
  localparam logic [ISTAT_W-1:0] IMASK_RESET = 3'h0;

  // ==============================================================
  // buffer types
  typedef enum logic [1:0] {
    TPER_BUF_NONE,
    TPER_BUF_TOUCH,
    TPER_BUF_RELEASE,
    TPER_BUF_BOTH
  } tper_buf_t;

  // control register layout, bit 0 is the mode
  typedef struct packed {
    tper_buf_t buf_type;
    logic buffered;
  } tper_ctrl_t;

  // one logged event: kind 1 = press, 0 = release
  typedef struct packed {
    logic press;
    logic [PTR_W-1:0] pad;
  } tper_entry_t;

endpackage : tper_pkg

// ===== src/tper_reader.sv
`timescale 1ns/1ps
`default_nettype none

module tper_reader
  import tper_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // pad electrodes, asynchronous
  input wire logic [PADS-1:0] PAD,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // interrupts
  output logic SENSE_IRQ,
  output logic INT
);

  // ==============================================================
  // state
  typedef struct packed {
    logic [PADS-1:0] pad_s1;
    logic [PADS-1:0] pad_s2;
    logic [PADS-1:0] seen;
    tper_ctrl_t ctrl;
    logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] mem;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [PTR_W:0] count;
    logic irq_pin;
    logic armed;
    logic [ISTAT_W-1:0] istat;
    logic [ISTAT_W-1:0] imask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } tper_state_t;

  localparam tper_state_t ST_RESET = '{
    pad_s1: '0, pad_s2: '0, seen: '0,
    ctrl: '{buf_type: TPER_BUF_NONE, buffered: 1'b0},
    mem: '0, wp: '0, rp: '0, count: '0,
    irq_pin: 1'b0, armed: 1'b1,
    istat: '0, imask: IMASK_RESET,
    pready: 1'b0, pslverr: 1'b0, prdata: '0, irq: 1'b0};

  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(FIFO_DEPTH);

  tper_state_t st;
  tper_state_t next_st;

  // ==============================================================
  // helpers
  // lowest set bit; several pads may change in one cycle
  function automatic logic [PTR_W-1:0] lowest(input logic [PADS-1:0] v);
    logic [PTR_W-1:0] r;
    r = '0;
    for (int i = PADS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = PTR_W'(i);
      end
    end
    return r;
  endfunction : lowest

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == OFF_CTRL || a == OFF_TOUCH || a == OFF_FIFO ||
           a == OFF_LEVEL || a == OFF_ISTAT || a == OFF_IMASK;
  endfunction : mapped

  // ==============================================================
  // next state
  always_comb begin
    logic setup;
    logic done;
    logic wr;
    logic fifo_rd;
    logic pop;
    logic push;
    logic fault;
    logic touch_evt;
    logic pressed;
    logic log_it;
    logic [PADS-1:0] diff;
    logic [PTR_W-1:0] idx;
    logic [ISTAT_W-1:0] set_bits;
    logic [ISTAT_W-1:0] clr_bits;
    tper_entry_t ent;
    setup = 1'b0;
    done = 1'b0;
    wr = 1'b0;
    fifo_rd = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    fault = 1'b0;
    touch_evt = 1'b0;
    pressed = 1'b0;
    log_it = 1'b0;
    diff = '0;
    idx = '0;
    set_bits = '0;
    clr_bits = '0;
    ent = '0;
    next_st = st;

    // two-flop pad synchroniser
    next_st.pad_s1 = PAD;
    next_st.pad_s2 = st.pad_s1;

    // apb phases: answer is ready in the first access cycle
    setup = PSEL && !PENABLE;
    done = PSEL && PENABLE && st.pready;
    wr = done && PWRITE;
    fifo_rd = done && !PWRITE && PADDR == OFF_FIFO;
    pop = fifo_rd && st.count != '0;
    next_st.pready = setup;
    next_st.pslverr = setup && !mapped(PADDR);

    // read data is latched at setup; pops only happen later at done
    if (setup && !PWRITE) begin
      next_st.prdata = '0;
      case (PADDR)
        OFF_CTRL: next_st.prdata[2:0] = st.ctrl;
        OFF_TOUCH: next_st.prdata[PADS-1:0] = st.pad_s2;
        OFF_FIFO: begin
          next_st.prdata[FIFO_EMPTY_BIT] = st.count == '0;
          next_st.prdata[ENTRY_W-1:0] = st.mem[st.rp];
        end
        OFF_LEVEL: next_st.prdata[PTR_W:0] = st.count;
        OFF_ISTAT: next_st.prdata[ISTAT_W-1:0] = st.istat;
        OFF_IMASK: next_st.prdata[ISTAT_W-1:0] = st.imask;
        default: next_st.prdata = '0;
      endcase
    end

    // one pad change handled per cycle, lowest pad first; a change undone before its turn is lost
    diff = st.pad_s2 ^ st.seen;
    touch_evt = |diff;
    idx = lowest(diff);
    pressed = st.pad_s2[idx];
    if (touch_evt) begin
      next_st.seen[idx] = pressed;
    end
    // buffer type none, or non-buffered mode with any type, logs nothing
    log_it = touch_evt && st.ctrl.buffered &&
             ((pressed && st.ctrl.buf_type[0]) ||
              (!pressed && st.ctrl.buf_type[1]));
    fault = log_it && st.count == DEPTH_CNT && !pop;
    push = log_it && !fault;
    ent.press = pressed;
    ent.pad = idx;

    // fifo pointers
    if (push) begin
      next_st.mem[st.wp] = ent;
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.count = st.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

    // sensor pin: dropped by a fifo read, re-armed only when empty
    if (fifo_rd) begin
      next_st.irq_pin = 1'b0;
      next_st.armed = 1'b0;
    end else if (st.count == '0) begin
      next_st.armed = 1'b1;
    end
    if (!st.ctrl.buffered && wr == 1'b0 && done &&
        PADDR == OFF_TOUCH) begin
      next_st.irq_pin = 1'b0;
    end
    // a non-buffered touch event sets the pin even during a clearing touch read
    if ((push && st.armed && !fifo_rd) || fault ||
        (touch_evt && !st.ctrl.buffered)) begin
      next_st.irq_pin = 1'b1;
    end

    // register writes
    if (wr) begin
      case (PADDR)
        OFF_CTRL: begin
          // reconfiguring flushes stale events of the old type
          next_st.ctrl = tper_ctrl_t'(PWDATA[2:0]);
          next_st.wp = '0;
          next_st.rp = '0;
          next_st.count = '0;
          next_st.armed = 1'b1;
          next_st.irq_pin = 1'b0;
        end
        OFF_ISTAT: clr_bits = PWDATA[ISTAT_W-1:0];
        OFF_IMASK: next_st.imask = PWDATA[ISTAT_W-1:0];
        default: ;
      endcase
    end

    // sticky status, set wins over a write-one clear
    set_bits[IS_TOUCH] = touch_evt;
    set_bits[IS_FAULT] = fault;
    set_bits[IS_DATA] = push;
    next_st.istat = (st.istat & ~clr_bits) | set_bits;
    next_st.irq = |(next_st.istat & next_st.imask);
  end

  // ==============================================================
  // state register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs come straight from flip-flops
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign SENSE_IRQ = st.irq_pin;
  assign INT = st.irq;

endmodule : tper_reader

`default_nettype wire

// ===== verification/tper_reader_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bus and pin checks
module tper_checker
  import tper_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // sensor pin
  input wire logic SENSE_IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_done;
    PSEL && PENABLE && PREADY;
  endsequence
  a_ready_next: assert property (s_setup |=> PREADY)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_ready_phase: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  a_err_unmapped: assert property (s_setup ##0 PADDR > OFF_IMASK |=> PSLVERR)
    else $error("no error on unmapped");
  a_err_mapped: assert property (s_setup ##0 PADDR <= OFF_IMASK
    && PADDR[1:0] == 2'h0 |=> !PSLVERR) else $error("error on mapped");
  a_err_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error read not zero");
  a_irq_drop: assert property (s_done ##0 !PWRITE && PADDR == OFF_FIFO
    |=> !SENSE_IRQ) else $error("pin kept after pop");
  // pin only falls on a completed access, never by itself
  a_irq_hold: assert property ($fell(SENSE_IRQ) |->
    $past(PSEL && PENABLE && PREADY)) else $error("pin fell");
endmodule : tper_checker
bind tper_reader tper_checker u_chk(.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SENSE_IRQ(SENSE_IRQ));
`default_nettype wire

// ===== verification/tper_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// electrode array, one level per pad
module tper_pad_model (
  // clock
  input wire logic clk,
  // wanted and shown pad state
  input wire logic [7:0] want,
  output logic [7:0] pad
);
  // changes land after an edge, asynchronous to the sampler
  always_ff @(posedge clk) begin
    pad <= #2 want;
  end
endmodule : tper_pad_model
`default_nettype wire

// ===== verification/touch_pad_event_reader_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module touch_pad_event_reader_tb;
  import tper_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, want = 0, pad;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, irq, int_o;
  int errors = 0, n_compared = 0;
  tper_pad_model pm(.clk(clk), .want(want), .pad(pad));
  tper_reader dut(.CLK_SYS(clk), .RST_N(rst_n), .PAD(pad), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SENSE_IRQ(irq), .INT(int_o));
  initial forever #5 clk = ~clk;
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one transfer; waits on pready, watchdog cuts a hang
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = pslverr ? 32'hdead : prdata;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(r, e);
  endtask : rd
  task automatic pads(input logic [7:0] v);
    @(posedge clk);
    want <= v;
    repeat (8) @(posedge clk);
  endtask : pads
  task automatic pin(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : pin
  task automatic t_regs();
    rd(OFF_CTRL, 0);
    rd(OFF_IMASK, 0);
    rd(OFF_LEVEL, 0);
    rd(OFF_FIFO, 32'h100);
    rd(8'h40, 32'hdead);
  endtask : t_regs
  task automatic t_multi();
    pads(8'h0a);
    pin(1);
    rd(OFF_TOUCH, 32'h0a);
    chk(32'($countones(r)), 2);
    rd(OFF_LEVEL, 0);
    pin(0);
    pads(0);
    rd(OFF_TOUCH, 0);
  endtask : t_multi
  task automatic t_fifo();
    apb(1, OFF_CTRL, 3);
    pads(8'h24);
    pin(1);
    rd(OFF_FIFO, 32'h0a);
    repeat (10) @(posedge clk);
    pin(0);
    pads(8'h64);
    pin(0);
    rd(OFF_FIFO, 32'h0d);
    rd(OFF_FIFO, 32'h0e);
    rd(OFF_FIFO, 32'h100);
    pads(8'he4);
    pin(1);
    rd(OFF_FIFO, 32'h0f);
    pads(0);
    rd(OFF_FIFO, 32'h100);
  endtask : t_fifo
  task automatic t_kinds();
    apb(1, OFF_CTRL, 7);
    pads(8'h01);
    pads(0);
    rd(OFF_FIFO, 32'h08);
    rd(OFF_FIFO, 32'h00);
    apb(1, OFF_CTRL, 5);
    pads(8'h02);
    pads(0);
    rd(OFF_FIFO, 32'h01);
    rd(OFF_FIFO, 32'h100);
  endtask : t_kinds
  task automatic t_irq();
    apb(1, OFF_IMASK, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, int_o}, 1);
    apb(1, OFF_ISTAT, 32'h7);
    rd(OFF_ISTAT, 0);
    chk({31'h0, int_o}, 0);
    apb(1, OFF_IMASK, 32'h0);
    pads(8'h80);
    rd(OFF_ISTAT, 32'h1);
    chk({31'h0, int_o}, 0);
  endtask : t_irq
  // ==========
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_regs();
    t_multi();
    t_fifo();
    t_kinds();
    t_irq();
    summarize();
  end
  initial begin
    #100000;
    errors++;
    summarize();
  end
endmodule : touch_pad_event_reader_tb
`default_nettype wire
